// *** hw/fsprg_map.svh ***
// Purpose: offsets, field positions, reset values and counts of the synthesizer programming block
// Assumes: 24-bit serial words, control bits in the two lowest positions
// Notes: definitions only
`ifndef FSPRG_MAP_SVH
`define FSPRG_MAP_SVH

// word geometry and destination codes
`define FSPRG_WORD_W 24
`define FSPRG_DST_FB 2'h0
`define FSPRG_DST_REF 2'h1
`define FSPRG_DST_CTL 2'h2
`define FSPRG_DST_NS 2'h3

// feedback divider word fields
`define FSPRG_FB_QUICK 23
`define FSPRG_FB_INT_HI 22
`define FSPRG_FB_INT_LO 14
`define FSPRG_FB_PARTIAL_STEP_COUNT_HI 13
`define FSPRG_FB_PARTIAL_STEP_COUNT_LO 2

// reference divider word fields
`define FSPRG_RF_LOAD 23
`define FSPRG_RF_MUX_HI 22
`define FSPRG_RF_MUX_LO 20
`define FSPRG_RF_PRESC 18
`define FSPRG_RF_R_HI 17
`define FSPRG_RF_R_LO 14
`define FSPRG_RF_MOD_HI 13
`define FSPRG_RF_MOD_LO 2

// control word fields
`define FSPRG_CT_CRST 2
`define FSPRG_CT_CPTRI 3
`define FSPRG_CT_PDN 4
`define FSPRG_CT_LOCK_PREC 5
`define FSPRG_CT_POL 6
`define FSPRG_CT_CP_HI 10
`define FSPRG_CT_CP_LO 7
`define FSPRG_CT_DBL 11

// test output selector codes
`define FSPRG_MUX_TRI 3'h0
`define FSPRG_MUX_DLD 3'h1
`define FSPRG_MUX_NDIV 3'h2
`define FSPRG_MUX_HIGH 3'h3
`define FSPRG_MUX_RDIV 3'h4
`define FSPRG_MUX_ALD 3'h5
`define FSPRG_MUX_QSW 3'h6
`define FSPRG_MUX_LOW 3'h7

// pin positions in the synchroniser vector
`define FSPRG_PIN_SCLK 0
`define FSPRG_PIN_SDAT 1
`define FSPRG_PIN_LE 2
`define FSPRG_PIN_REF 3
`define FSPRG_PIN_NDIV 4
`define FSPRG_PIN_ESML 5
`define FSPRG_PIN_EBIG 6

// lock detector cycle counts, charge pump maximum and denominator reset value
`define FSPRG_LOCK_CYC_LO 24
`define FSPRG_LOCK_CYC_HI 40
`define FSPRG_CP_MAX 4'hF
`define FSPRG_MOD_RST 12'h000
`endif

// *** hw/fsprg_pkg.sv ***
// Purpose: types of the synthesizer programming block
// Assumes: fsprg_map.svh gives all numbers
// Notes: whole block state is one packed struct
package fsprg_pkg;
  typedef struct packed {
    logic [6:0] sy1;       // synchroniser stage one
    logic [6:0] sy2;       // synchroniser stage two
    logic [6:0] sy3;       // synchroniser stage three
    logic [6:0] flt;       // agreed pin levels
    logic [23:0] shreg;    // serial input register
    logic quick;           // quick-settle request
    logic [8:0] int_val;   // integer division value
    logic [11:0] partial_step_count;     // partial step count
    logic [11:0] den_act;  // interpolator denominator in use
    logic [11:0] den_pend; // denominator waiting for a feedback write
    logic [11:0] resync;   // interpolator resync delay
    logic [2:0] mux_sel;   // test output select
    logic presc;           // 1 = 8/9 prescaler
    logic [3:0] r_div;     // reference divide ratio
    logic cnt_rst;         // counter reset bit
    logic cp_tri;          // charge pump tri-state bit
    logic pwr_dn;          // software power-down bit
    logic lock_precision_select; // 1 = longer lock run
    logic pol;             // phase detector polarity
    logic [3:0] cp_cur;    // programmed charge pump current
    logic dbl;             // reference doubler enable
    logic [21:0] ns_word;  // noise and spur payload
    logic [3:0] rcnt;      // reference counter
    logic tick;            // phase detector reference pulse
    logic [5:0] lock_cnt;  // consecutive good cycles
    logic lock;            // digital lock indicator
    logic [3:0] cp_eff;    // charge pump current applied
    logic cp_tri_eff;      // charge pump tri-stated
    logic cnt_hold;        // counters held
    logic test_out;        // test pin level
    logic test_oe_n;       // test pin driven when low
    logic chan_new;        // pulse: feedback divider written
  } fsprg_state_type;
endpackage

// *** hw/fsprg_core.sv ***
// Purpose: serial programming, double-buffered interpolator denominator, reference counter and lock detect
// Assumes: serial and analog pins are asynchronous to i_ref_clk; phase error windows come from comparators
// Notes: the test pin is three-state style: two signals, enable active low
// Operation
// - low bits 00 load feedback divider word
// - feedback word holds nine-bit integer value
// - quick-settle forces maximum charge pump current
// - quick-settle switch grounds test pin
// - low bits 01 load reference divider word
// - load bit stores resync delay instead
// - bits 22..20 select test pin source
// - lock after 24 good cycles
// - lock holds until new channel, large error or power-down
// - precision bit needs 40 good cycles
// - reference counter divides by one to fifteen
// - new denominator applies after feedback write
// - low bits 10 load control word
// - control bit two holds counters reset
// - control bit three tri-states charge pump
// - control bit four powers down, keeps registers
// - power-down loads counters, tri-states, clears lock
// - control bit six sets detector polarity
// - control bits 7..10 set pump current
// - doubler bit selects falling or both edges
// - low bits 11 load noise spur word
`include "fsprg_map.svh"
module fsprg_core
  import fsprg_pkg::*;
#(
  parameter int LOCK_COUNT_LO = `FSPRG_LOCK_CYC_LO, // good cycles, precision bit low
  parameter int LOCK_COUNT_HI = `FSPRG_LOCK_CYC_HI  // good cycles, precision bit high
)(
  input wire logic i_ref_clk,          // 25 MHz system clock
  input wire logic i_rst_n,            // synchronous reset, active low
  input wire logic i_sclk,             // serial clock pin
  input wire logic i_sdata,            // serial data pin
  input wire logic i_le,               // load strobe pin
  input wire logic i_reference_input,  // reference pin
  input wire logic i_ndiv_out,         // feedback divider output
  input wire logic i_err_small,        // phase error below 15 ns
  input wire logic i_err_large,        // phase error above 30 ns
  output logic o_quick_settle,         // quick-settle bit
  output logic [8:0] o_int_value,      // integer division value
  output logic [11:0] o_partial_step_count, // fractional numerator
  output logic [11:0] o_interpolator_denominator, // denominator in use
  output logic [11:0] o_resync_delay,  // interpolator resync delay
  output logic o_prescaler_89,         // 1 = 8/9 prescaler
  output logic [3:0] o_r_div,          // reference divide ratio
  output logic o_pd_polarity,          // detector polarity
  output logic o_doubler_en,           // doubler enabled
  output logic o_power_down,           // software power-down
  output logic o_counter_hold,         // counters held in load state
  output logic o_cp_tristate,          // charge pump tri-stated
  output logic [3:0] o_cp_current,     // charge pump current applied
  output logic [21:0] o_noise_spur_word, // noise and spur payload
  output logic o_pfd_ref_tick,         // one pulse per detector reference cycle
  output logic o_lock_detect,          // digital lock indicator
  output logic o_test_output_pin_o,    // test pin output level
  output logic o_test_output_pin_oe_n  // test pin drive enable, low drives
);

  // refuse counts the six-bit counter cannot reach
  if (LOCK_COUNT_LO < 1 || LOCK_COUNT_LO > 63 || LOCK_COUNT_HI < 1 || LOCK_COUNT_HI > 63)
  begin : g_bad_count
    $error("lock counts must lie in 1..63");
  end

  fsprg_state_type st_ff;     // all registered state
  fsprg_state_type nxt_st;    // next state
  logic [6:0] pins;           // raw pin bundle

  assign pins = {i_err_large, i_err_small, i_ndiv_out, i_reference_input, i_le, i_sdata, i_sclk};

  // rising edge of an agreed pin level
  function automatic logic rose(input fsprg_state_type s, input int idx);
    rose = (s.sy2[idx] == s.sy3[idx]) && s.sy3[idx] && !s.flt[idx];
  endfunction

  // falling edge of an agreed pin level
  function automatic logic fell(input fsprg_state_type s, input int idx);
    fell = (s.sy2[idx] == s.sy3[idx]) && !s.sy3[idx] && s.flt[idx];
  endfunction

  // next-state logic for the whole block
  always_comb
  begin
    logic [23:0] w;        // word at the load strobe
    logic ref_edge;        // active reference edge
    logic [3:0] ratio;     // effective divide ratio
    logic [5:0] thr;       // lock threshold in use
    logic hold;            // counters forced to load state
    w = st_ff.shreg;
    ref_edge = 1'b0;
    ratio = 4'h1;
    thr = 6'h00;
    hold = 1'b0;
    nxt_st = st_ff;
    nxt_st.chan_new = 1'b0;
    nxt_st.tick = 1'b0;

    // three-stage synchroniser; a level counts once stages two and three agree
    nxt_st.sy1 = pins;
    nxt_st.sy2 = st_ff.sy1;
    nxt_st.sy3 = st_ff.sy2;
    for (int i = 0; i < 7; i++)
    begin
      if (st_ff.sy2[i] == st_ff.sy3[i])
      begin
        nxt_st.flt[i] = st_ff.sy3[i];
      end
    end

    // shift msb first on serial clock rise; the input register works in power-down too
    if (rose(st_ff, `FSPRG_PIN_SCLK))
    begin
      nxt_st.shreg = {st_ff.shreg[22:0], st_ff.flt[`FSPRG_PIN_SDAT]};
    end

    // transfer on load strobe rise, steered by the two low bits
    if (rose(st_ff, `FSPRG_PIN_LE))
    begin
      if (w[1:0] == `FSPRG_DST_FB)
      begin
        nxt_st.quick = w[`FSPRG_FB_QUICK];
        nxt_st.int_val = w[`FSPRG_FB_INT_HI:`FSPRG_FB_INT_LO];
        // the host keeps this at or below the denominator; no clamp here
        nxt_st.partial_step_count = w[`FSPRG_FB_PARTIAL_STEP_COUNT_HI:`FSPRG_FB_PARTIAL_STEP_COUNT_LO];
        nxt_st.den_act = st_ff.den_pend;
        nxt_st.chan_new = 1'b1;
      end
      else if (w[1:0] == `FSPRG_DST_REF)
      begin
        if (w[`FSPRG_RF_LOAD])
        begin
          nxt_st.resync = w[`FSPRG_RF_MOD_HI:`FSPRG_RF_MOD_LO];
        end
        else
        begin
          // held back until the next feedback write
          nxt_st.den_pend = w[`FSPRG_RF_MOD_HI:`FSPRG_RF_MOD_LO];
        end
        nxt_st.mux_sel = w[`FSPRG_RF_MUX_HI:`FSPRG_RF_MUX_LO];
        // prescaler minimum division is the host's concern
        nxt_st.presc = w[`FSPRG_RF_PRESC];
        nxt_st.r_div = w[`FSPRG_RF_R_HI:`FSPRG_RF_R_LO];
      end
      else if (w[1:0] == `FSPRG_DST_CTL)
      begin
        nxt_st.cnt_rst = w[`FSPRG_CT_CRST];
        nxt_st.cp_tri = w[`FSPRG_CT_CPTRI];
        nxt_st.pwr_dn = w[`FSPRG_CT_PDN];
        nxt_st.lock_precision_select = w[`FSPRG_CT_LOCK_PREC];
        nxt_st.pol = w[`FSPRG_CT_POL];
        nxt_st.cp_cur = w[`FSPRG_CT_CP_HI:`FSPRG_CT_CP_LO];
        nxt_st.dbl = w[`FSPRG_CT_DBL];
      end
      else
      begin
        nxt_st.ns_word = w[23:2];
      end
    end

    // derived controls, registered so outputs come straight from flip-flops
    hold = st_ff.cnt_rst || st_ff.pwr_dn;
    nxt_st.cnt_hold = hold;
    nxt_st.cp_tri_eff = st_ff.cp_tri || st_ff.pwr_dn;
    nxt_st.cp_eff = st_ff.quick ? `FSPRG_CP_MAX : st_ff.cp_cur;

    // active reference edge: falling only, or both when doubled
    if (st_ff.dbl)
    begin
      ref_edge = rose(st_ff, `FSPRG_PIN_REF) || fell(st_ff, `FSPRG_PIN_REF);
    end
    else
    begin
      ref_edge = fell(st_ff, `FSPRG_PIN_REF);
    end

    // reference counter; a zero ratio is served as one rather than stalling
    ratio = (st_ff.r_div == 4'h0) ? 4'h1 : st_ff.r_div;
    if (hold)
    begin
      nxt_st.rcnt = 4'h0;
    end
    else if (ref_edge)
    begin
      if (st_ff.rcnt + 4'h1 >= ratio)
      begin
        nxt_st.rcnt = 4'h0;
        nxt_st.tick = 1'b1;
      end
      else
      begin
        nxt_st.rcnt = st_ff.rcnt + 4'h1;
      end
    end

    // lock detector: count consecutive small-error cycles up to the threshold
    thr = st_ff.lock_precision_select ? 6'(LOCK_COUNT_HI) : 6'(LOCK_COUNT_LO);
    if (st_ff.pwr_dn || st_ff.chan_new)
    begin
      nxt_st.lock_cnt = 6'h00;
      nxt_st.lock = 1'b0;
    end
    else if (st_ff.tick)
    begin
      if (st_ff.flt[`FSPRG_PIN_EBIG])
      begin
        nxt_st.lock_cnt = 6'h00;
        nxt_st.lock = 1'b0;
      end
      else if (st_ff.flt[`FSPRG_PIN_ESML])
      begin
        if (st_ff.lock_cnt + 6'h01 >= thr)
        begin
          nxt_st.lock = 1'b1;
          nxt_st.lock_cnt = thr;
        end
        else
        begin
          nxt_st.lock_cnt = st_ff.lock_cnt + 6'h01;
        end
      end
      else
      begin
        // middle band breaks the run but does not drop a held lock
        nxt_st.lock_cnt = 6'h00;
      end
    end

    // test pin multiplexer; three-state and open-drain codes release the pin
    nxt_st.test_out = 1'b0;
    nxt_st.test_oe_n = 1'b0;
    case (st_ff.mux_sel)
      `FSPRG_MUX_TRI:
      begin
        nxt_st.test_oe_n = 1'b1;
      end
      `FSPRG_MUX_DLD:
      begin
        nxt_st.test_out = st_ff.lock;
      end
      `FSPRG_MUX_NDIV:
      begin
        nxt_st.test_out = st_ff.flt[`FSPRG_PIN_NDIV];
      end
      `FSPRG_MUX_HIGH:
      begin
        nxt_st.test_out = 1'b1;
      end
      `FSPRG_MUX_RDIV:
      begin
        nxt_st.test_out = st_ff.tick;
      end
      `FSPRG_MUX_ALD:
      begin
        // open drain: pull low while out of lock
        nxt_st.test_oe_n = st_ff.lock;
      end
      `FSPRG_MUX_QSW:
      begin
        // ground while quick-settle is on, released otherwise
        nxt_st.test_oe_n = !st_ff.quick;
      end
      default:
      begin
        nxt_st.test_out = 1'b0;
      end
    endcase
  end

  // single state register; reset loads constants only
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
      st_ff.test_oe_n <= 1'b1;
      st_ff.den_act <= `FSPRG_MOD_RST;
      st_ff.den_pend <= `FSPRG_MOD_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from state flip-flops
  assign o_quick_settle = st_ff.quick;
  assign o_int_value = st_ff.int_val;
  assign o_partial_step_count = st_ff.partial_step_count;
  assign o_interpolator_denominator = st_ff.den_act;
  assign o_resync_delay = st_ff.resync;
  assign o_prescaler_89 = st_ff.presc;
  assign o_r_div = st_ff.r_div;
  assign o_pd_polarity = st_ff.pol;
  assign o_doubler_en = st_ff.dbl;
  assign o_power_down = st_ff.pwr_dn;
  assign o_counter_hold = st_ff.cnt_hold;
  assign o_cp_tristate = st_ff.cp_tri_eff;
  assign o_cp_current = st_ff.cp_eff;
  assign o_noise_spur_word = st_ff.ns_word;
  assign o_pfd_ref_tick = st_ff.tick;
  assign o_lock_detect = st_ff.lock;
  assign o_test_output_pin_o = st_ff.test_out;
  assign o_test_output_pin_oe_n = st_ff.test_oe_n;

  // helper: a load strobe with a given destination code
  sequence s_load(logic [1:0] code);
    rose(st_ff, `FSPRG_PIN_LE) && st_ff.shreg[1:0] == code;
  endsequence

  a_fb_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_load(`FSPRG_DST_FB) |=> o_int_value == $past(st_ff.shreg[22:14]) && st_ff.chan_new)
    else $error("feedback word not routed");
  a_den_buffer: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_load(`FSPRG_DST_REF) |=> $stable(o_interpolator_denominator))
    else $error("denominator changed without feedback write");
  a_resync_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_load(`FSPRG_DST_REF) ##0 st_ff.shreg[23] |=> $stable(st_ff.den_pend)
      && o_resync_delay == $past(st_ff.shreg[13:2]))
    else $error("load bit did not redirect to resync delay");
  a_ctl_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_load(`FSPRG_DST_CTL) |=> o_power_down == $past(st_ff.shreg[4])
      ##1 o_counter_hold == (st_ff.cnt_rst || o_power_down))
    else $error("control word not applied");
  a_quick_cur: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_ff.quick ##1 st_ff.quick |-> o_cp_current == `FSPRG_CP_MAX)
    else $error("quick-settle current not maximum");
  a_qsw_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_ff.mux_sel == `FSPRG_MUX_QSW |=> o_test_output_pin_oe_n == !$past(st_ff.quick) && !o_test_output_pin_o)
    else $error("quick-settle switch pin wrong");
  a_pd_tristate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_power_down |=> o_cp_tristate && o_counter_hold && !o_lock_detect)
    else $error("power-down effects missing");
  a_lock_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_ff.tick && st_ff.flt[`FSPRG_PIN_EBIG] |=> !o_lock_detect)
    else $error("lock held through large error");
  a_lock_count: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_lock_detect) |-> $past(st_ff.lock_cnt)
      == (st_ff.lock_precision_select ? 6'(LOCK_COUNT_HI - 1) : 6'(LOCK_COUNT_LO - 1)))
    else $error("lock asserted at wrong count");
  a_hold_ref: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_ff.cnt_rst |=> !o_pfd_ref_tick)
    else $error("reference counter ran while held");
endmodule

// *** verif/fsprg_host_model.sv ***
// Purpose: host side of the three-wire programming link
// Assumes: every line phase is held for 4 reference clocks
// Notes: serial clock stands low between frames
module fsprg_host_model (
  input wire logic i_clk, // bench clock
  output logic o_sclk,    // serial clock
  output logic o_sdata,   // serial data
  output logic o_le       // load strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels before the first frame
  initial
  begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_le = 1'b0;
  end
  // step n clocks, then change just after the edge
  task automatic gap(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // one frame: 24 bits msb first, then the strobe pulse
  task automatic send(input logic [23:0] w);
    gap(1);
    for (int i = 23; i >= 0; i--)
    begin
      o_sdata = w[i];
      gap(4);
      o_sclk = 1'b1; // sampled on this rise
      gap(4);
      o_sclk = 1'b0;
    end
    o_sdata = ~w[0]; // data no longer valid, so no stale copy
    gap(4);
    o_le = 1'b1; // transfer to the addressed word
    gap(4);
    o_le = 1'b0;
    gap(4);
  endtask
endmodule

// *** verif/partial_step_count_synth_program_regs_tb.sv ***
// Purpose: self-checking bench of the synthesizer programming block
// Assumes: short lock counts through parameters
// Notes: expectations queued, compared by a watcher process
module partial_step_count_synth_program_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LK_LO = 6; // shortened lock run, precision low
  localparam int LK_HI = 9; // shortened lock run, precision high
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic ref_in = 1'b0;
  logic ndiv = 1'b1;
  logic err_s = 1'b0;
  logic err_l = 1'b0;
  wire sclk, sdata, le;
  logic q, lk, pres, dbl, pd, hold, tri_s, test_o, test_oe_n, tick, pol_w;
  logic [8:0] intv;
  logic [11:0] partial_step_count, den, rsy;
  logic [3:0] rdiv, cp;
  logic [21:0] nsw;
  int fails = 0;
  int num_checks = 0;
  int seed = 56207;
  int tcnt = 0;
  int ivl;
  logic [63:0] expq[$]; // selector and expected value
  logic [63:0] nt; // note being compared
  logic [21:0] nsv; // noise and spur payload sent
  // interval table: {expected clocks, doubler, ratio}
  logic [15:0] ivl_tab[4] = '{16'h0801, 16'h1803, 16'h780F, 16'h0C13};
  event chk_ev;
  logic [11:0] d, d2;
  logic [9:0] c;
  logic [3:0] r;
  always #20 i_ref_clk = ~i_ref_clk;
  // reference pin, period 8 clocks
  always
  begin
    repeat (4) @(posedge i_ref_clk);
    #1 ref_in = ~ref_in;
  end
  fsprg_host_model fsprg_host_model_inst (.i_clk(i_ref_clk), .o_sclk(sclk), .o_sdata(sdata), .o_le(le));
  fsprg_core #(.LOCK_COUNT_LO(LK_LO), .LOCK_COUNT_HI(LK_HI)) fsprg_core_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_sdata(sdata), .i_le(le),
    .i_reference_input(ref_in), .i_ndiv_out(ndiv), .i_err_small(err_s), .i_err_large(err_l),
    .o_quick_settle(q), .o_int_value(intv), .o_partial_step_count(partial_step_count), .o_interpolator_denominator(den),
    .o_resync_delay(rsy), .o_prescaler_89(pres), .o_r_div(rdiv), .o_pd_polarity(pol_w), .o_doubler_en(dbl),
    .o_power_down(pd), .o_counter_hold(hold), .o_cp_tristate(tri_s), .o_cp_current(cp),
    .o_noise_spur_word(nsw), .o_pfd_ref_tick(tick), .o_lock_detect(lk),
    .o_test_output_pin_o(test_o), .o_test_output_pin_oe_n(test_oe_n));
  // ticks since power-down was last left
  always @(posedge i_ref_clk)
    if (pd)
      tcnt <= 0;
    else if (tick)
      tcnt <= tcnt + 1;
  // observed value for each selector
  function automatic logic [31:0] obs(input logic [31:0] s);
    case (s)
      0: obs = {10'h000, q, intv, partial_step_count};
      1: obs = {20'h00000, den};
      2: obs = {20'h00000, rsy};
      3: obs = {27'h0, pres, rdiv};
      4: obs = {23'h0, pol_w, dbl, pd, hold, tri_s, cp};
      5: obs = {10'h000, nsw};
      6: obs = {31'h0, lk};
      7: obs = {30'h0, test_o, test_oe_n};
      8: obs = {31'h0, test_oe_n};
      default: obs = ivl;
    endcase
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // watcher: drains every queued note, oldest first, whenever results are announced
  always
  begin
    @(chk_ev);
    while (expq.size() > 0)
    begin
      nt = expq.pop_front();
      check(obs(nt[63:32]), nt[31:0]); // tags stand at each note
    end
  end
  task automatic note(input int s, input logic [31:0] e);
    expq.push_back({s[31:0], e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic fire();
    -> chk_ev;
    cyc(1);
  endtask
  task automatic wr(input logic [23:0] w);
    fsprg_host_model_inst.send(w);
    cyc(4); // results settle 5 edges after the strobe
  endtask
  // control word from bits 11..2
  task automatic ctl(input logic [9:0] b);
    wr({12'h000, b, 2'b10});
  endtask
  task automatic refw(input logic ld, input logic [2:0] m, input logic [3:0] rr, input logic [11:0] dd);
    wr({ld, m, 1'b0, 1'b1, rr, dd, 2'b01});
  endtask
  task automatic wait_cnt(input int n);
    for (int i = 0; i < 4000 && tcnt < n; i++)
      cyc(1);
  endtask
  // lock must be low one tick short of the run and high at its end
  task automatic lock_run(input int n);
    wait_cnt(n - 1);
    cyc(1);
    note(6, 0);
    fire();
    wait_cnt(n);
    cyc(1);
    note(6, 1);
    fire();
  endtask
  task automatic finish_test();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial
  begin
    #1000000;
    fails++;
    finish_test();
  end
  initial
  begin
    cyc(8);
    i_rst_n = 1'b1;
    cyc(4);
    note(0, 0);
    note(4, 0);
    note(8, 1);
    fire();
    d = 12'($unsigned($random(seed))) | 12'h001;
    r = 4'($unsigned($random(seed)));
    refw(1'b0, 3'h0, r, d);
    note(3, {1'b1, r});
    note(1, 0); // denominator still pending
    fire();
    intv_w(1'b1, d);
    note(1, d); // applied by the feedback write
    note(4, 9'h00F);
    fire();
    d2 = 12'($unsigned($random(seed)));
    refw(1'b1, 3'h0, r, d2);
    note(2, d2);
    note(1, d);
    fire();
    intv_w(1'b0, d);
    for (int k = 0; k < 6; k++)
    begin
      c = 10'($unsigned($random(seed)));
      ctl(c);
      note(4, {c[4], c[9], c[2], c[0] | c[2], c[1] | c[2], c[8:5]});
      note(3, {1'b1, r}); // retained in power-down
      fire();
    end
    nsv = 22'($unsigned($random(seed)));
    wr({nsv, 2'b11});
    note(5, {10'h000, nsv});
    fire();
    ctl(10'h001);
    for (int k = 0; k < 8; k++)
    begin
      refw(1'b0, k[2:0], 4'h1, d);
      if (k == 0 || k == 6)
        note(8, 1);
      else
        note(7, {(k == 2 || k == 3), 1'b0});
      fire();
    end
    refw(1'b0, 3'h6, 4'h1, d); // quick switch on the test pin
    intv_w(1'b1, d);
    note(7, 0); // quick switch grounds the pin
    fire();
    intv_w(1'b0, d);
    ctl(10'h000);
    foreach (ivl_tab[i])
    begin
      refw(1'b0, 3'h0, ivl_tab[i][3:0], d);
      ctl({ivl_tab[i][4], 9'h000});
      measure();
      note(9, ivl_tab[i][15:8]);
      fire();
    end
    err_s = 1'b1;
    ctl(10'h004);
    ctl(10'h000);
    lock_run(LK_LO);
    err_s = 1'b0;
    err_l = 1'b1;
    wait_cnt(tcnt + 2);
    cyc(6);
    note(6, 0); // large error drops lock
    fire();
    err_l = 1'b0;
    err_s = 1'b1;
    ctl(10'h00C);
    note(6, 0); // power-down resets lock
    note(4, 9'h070); // load state and tri-state
    fire();
    ctl(10'h008);
    lock_run(LK_HI);
    intv_w(1'b0, d);
    note(6, 0); // new channel drops lock
    fire();
    finish_test();
  end
  task automatic measure();
    int n;
    n = 0;
    for (int i = 0; i < 400 && tick !== 1'b1; i++)
      cyc(1);
    cyc(1);
    for (int i = 0; i < 400 && tick !== 1'b1; i++)
    begin
      cyc(1);
      n++;
    end
    ivl = n + 1;
  endtask
  // feedback write with a legal integer and a partial count within the denominator
  task automatic intv_w(input logic qk, input logic [11:0] dd);
    logic [8:0] iv;
    logic [11:0] fr;
    iv = 9'(91 + $unsigned($random(seed)) % 421);
    fr = 12'($unsigned($random(seed)) % (dd + 1));
    wr({qk, iv, fr, 2'b00});
    note(0, {10'h000, qk, iv, fr});
  endtask
endmodule
